/* verilog/ppc_consts.svh */
// Offsets, field positions, reset values and scale figures of the PA and PLL register slice
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPC_OFS_PA_SHUNT_CAP   8'h07
`define PPC_OFS_SYNTH_MODE     8'h08
`define PPC_OFS_CHARGE_PUMP    8'h09
`define PPC_OFS_TX_ENABLE_A    8'h0A
`define PPC_OFS_CARRIER_HIGH   8'h0B
`define PPC_OFS_CARRIER_MID    8'h0C
`define PPC_OFS_CARRIER_LOW    8'h0D
`define PPC_OFS_TX_ENABLE_B    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPC_CAP_MSB            4
`define PPC_CP_OFFSET_MSB      7
`define PPC_CP_OFFSET_LSB      6
`define PPC_FRAC_BIT           5
`define PPC_SYNTH_RESV_MSB     4
`define PPC_SYNTH_RESV_LSB     3
`define PPC_POSTDIV_MSB        2
`define PPC_POSTDIV_LSB        1
`define PPC_LO_SRC_BIT         0
`define PPC_CP_CUR_MSB         1
`define PPC_CP_RESV_MSB        7
`define PPC_CP_RESV_LSB        6
`define PPC_TXEN_BIT           2
`define PPC_TXEN_RESV_MSB      1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPC_RST_PA_SHUNT_CAP   8'h00
`define PPC_RST_SYNTH_MODE     8'h60
`define PPC_RST_CHARGE_PUMP    8'h00
`define PPC_RST_TX_ENABLE      8'h00
`define PPC_RST_CARRIER_HIGH   8'h13
`define PPC_RST_CARRIER_MID    8'hB0
`define PPC_RST_CARRIER_LOW    8'h00

// ----------------------------------------------------------------
// Scale figures
// ----------------------------------------------------------------
`define PPC_CAP_STEP_FF        13'h00AF
`define PPC_CAP_FF_W           13

`endif

/* verilog/ppc_pkg.sv */
// Types shared by the PA and PLL register slice
`default_nettype none
package ppc_pkg;

    // One flop bank holds the whole slice state
    typedef struct packed {
        logic [4:0]  pa_cap;
        logic [12:0] pa_cap_ff;
        logic [1:0]  cp_offset;
        logic        frac_sel;
        logic [1:0]  synth_resv;
        logic [1:0]  post_div;
        logic        lo_src;
        logic [1:0]  cp_resv;
        logic [1:0]  cp_cur;
        logic        tx_en;
        logic [1:0]  txen_resv_a;
        logic [1:0]  txen_resv_b;
        logic [23:0] carrier;
        logic [7:0]  rdata;
        logic        rvalid;
    } ppc_state_t;

endpackage
`default_nettype wire

/* verilog/ppc_regs.sv */
// PA shunt capacitance, synthesizer and carrier word configuration registers
`timescale 1ns/10ps
`default_nettype none
`include "ppc_consts.svh"

module ppc_regs
    import ppc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        rd_i,
    output var  logic [7:0]  rdata_o,
    output var  logic        rvalid_o,
    output var  logic [4:0]  pa_shunt_cap_code_o,
    output var  logic [12:0] pa_shunt_cap_ff_o,
    output var  logic [1:0]  cp_offset_level_o,
    output var  logic        synth_fraction_select_o,
    output var  logic [1:0]  vco_post_divider_o,
    output var  logic        lo_source_select_o,
    output var  logic [1:0]  cp_current_code_o,
    output var  logic        host_tx_enable_o,
    output var  logic [23:0] carrier_word_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // linear capacitance
    function automatic logic [12:0] cap_ff(input logic [4:0] code);
        cap_ff = 13'(code) * `PPC_CAP_STEP_FF;
    endfunction

    function automatic logic [7:0] read_mux(input ppc_state_t s, input logic [7:0] a);
        read_mux = 8'h00;
        case (a)
            `PPC_OFS_PA_SHUNT_CAP: read_mux = {3'h0, s.pa_cap};
            `PPC_OFS_SYNTH_MODE:   read_mux = {s.cp_offset, s.frac_sel, s.synth_resv,
                                               s.post_div, s.lo_src};
            `PPC_OFS_CHARGE_PUMP:  read_mux = {s.cp_resv, 4'h0, s.cp_cur};
            `PPC_OFS_TX_ENABLE_A:  read_mux = {5'h00, s.tx_en, s.txen_resv_a};
            `PPC_OFS_TX_ENABLE_B:  read_mux = {5'h00, s.tx_en, s.txen_resv_b};
            `PPC_OFS_CARRIER_HIGH: read_mux = s.carrier[23:16];
            `PPC_OFS_CARRIER_MID:  read_mux = s.carrier[15:8];
            `PPC_OFS_CARRIER_LOW:  read_mux = s.carrier[7:0];
            default:               read_mux = 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ppc_state_t st_r;
    ppc_state_t st_nxt;

    // Reset bytes as named constants so their fields can be picked apart
    localparam logic [7:0] RST_SYNTH = `PPC_RST_SYNTH_MODE;
    localparam logic [7:0] RST_CP    = `PPC_RST_CHARGE_PUMP;
    localparam logic [7:0] RST_TXEN  = `PPC_RST_TX_ENABLE;

    always_comb begin
        st_nxt = st_r;
        // Read sees the value before a same-cycle write
        st_nxt.rvalid = rd_i;
        st_nxt.rdata  = rd_i ? read_mux(st_r, addr_i) : st_r.rdata;
        if (wr_i) begin
            case (addr_i)
                `PPC_OFS_PA_SHUNT_CAP: begin
                    st_nxt.pa_cap = wdata_i[`PPC_CAP_MSB:0];
                end
                `PPC_OFS_SYNTH_MODE: begin
                    st_nxt.cp_offset  = wdata_i[`PPC_CP_OFFSET_MSB:`PPC_CP_OFFSET_LSB];
                    st_nxt.frac_sel   = wdata_i[`PPC_FRAC_BIT];
                    // Stored as written, host keeps them zero
                    st_nxt.synth_resv = wdata_i[`PPC_SYNTH_RESV_MSB:`PPC_SYNTH_RESV_LSB];
                    st_nxt.post_div   = wdata_i[`PPC_POSTDIV_MSB:`PPC_POSTDIV_LSB];
                    st_nxt.lo_src     = wdata_i[`PPC_LO_SRC_BIT];
                end
                `PPC_OFS_CHARGE_PUMP: begin
                    st_nxt.cp_cur  = wdata_i[`PPC_CP_CUR_MSB:0];
                    st_nxt.cp_resv = wdata_i[`PPC_CP_RESV_MSB:`PPC_CP_RESV_LSB];
                end
                `PPC_OFS_TX_ENABLE_A: begin
                    st_nxt.tx_en       = wdata_i[`PPC_TXEN_BIT];
                    st_nxt.txen_resv_a = wdata_i[`PPC_TXEN_RESV_MSB:0];
                end
                `PPC_OFS_TX_ENABLE_B: begin
                    st_nxt.tx_en       = wdata_i[`PPC_TXEN_BIT];
                    st_nxt.txen_resv_b = wdata_i[`PPC_TXEN_RESV_MSB:0];
                end
                `PPC_OFS_CARRIER_HIGH: st_nxt.carrier[23:16] = wdata_i;
                `PPC_OFS_CARRIER_MID:  st_nxt.carrier[15:8]  = wdata_i;
                `PPC_OFS_CARRIER_LOW:  st_nxt.carrier[7:0]   = wdata_i;
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        // Kept in step with the code so the analog side sees both at once
        st_nxt.pa_cap_ff = cap_ff(st_nxt.pa_cap);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r             <= '0;
            st_r.pa_cap      <= 5'(`PPC_RST_PA_SHUNT_CAP);
            st_r.cp_offset   <= RST_SYNTH[7:6];
            st_r.frac_sel    <= RST_SYNTH[5];
            st_r.post_div    <= RST_SYNTH[2:1];
            st_r.lo_src      <= RST_SYNTH[0];
            st_r.cp_cur      <= RST_CP[1:0];
            st_r.tx_en       <= RST_TXEN[2];
            st_r.carrier     <= {`PPC_RST_CARRIER_HIGH, `PPC_RST_CARRIER_MID,
                                 `PPC_RST_CARRIER_LOW};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata_o                 = st_r.rdata;
    assign rvalid_o                = st_r.rvalid;
    assign pa_shunt_cap_code_o     = st_r.pa_cap;
    assign pa_shunt_cap_ff_o       = st_r.pa_cap_ff;
    assign cp_offset_level_o       = st_r.cp_offset;
    assign synth_fraction_select_o = st_r.frac_sel;
    assign vco_post_divider_o      = st_r.post_div;
    assign lo_source_select_o      = st_r.lo_src;
    assign cp_current_code_o       = st_r.cp_cur;
    assign host_tx_enable_o        = st_r.tx_en;
    assign carrier_word_o          = st_r.carrier;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_cap_write;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_PA_SHUNT_CAP |=> pa_shunt_cap_code_o == $past(wdata_i[4:0]);
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("cap code not written");

    property p_cap_scale;
        @(posedge clk_i) disable iff (!rst_b_i)
        ##1 pa_shunt_cap_ff_o == 13'(pa_shunt_cap_code_o) * 13'h0AF;
    endproperty
    a_cap_scale: assert property (p_cap_scale) else $error("cap fF wrong");

    property p_offset_write;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_SYNTH_MODE |=> cp_offset_level_o == $past(wdata_i[7:6])
            && synth_fraction_select_o == $past(wdata_i[5]);
    endproperty
    a_offset_write: assert property (p_offset_write) else $error("offset not written");

    property p_frac_reset;
        @(posedge clk_i) disable iff (!rst_b_i)
        !$past(rst_b_i) |-> synth_fraction_select_o && !host_tx_enable_o
            && cp_offset_level_o == 2'h1 && carrier_word_o == 24'h13B000;
    endproperty
    a_frac_reset: assert property (p_frac_reset) else $error("bad reset value");

    property p_postdiv;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_SYNTH_MODE |=> vco_post_divider_o == $past(wdata_i[2:1]);
    endproperty
    a_postdiv: assert property (p_postdiv) else $error("divider not written");

    property p_lo_src;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_SYNTH_MODE |=> lo_source_select_o == $past(wdata_i[0]);
    endproperty
    a_lo_src: assert property (p_lo_src) else $error("LO source not written");

    property p_cp_cur;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_CHARGE_PUMP |=> cp_current_code_o == $past(wdata_i[1:0]);
    endproperty
    a_cp_cur: assert property (p_cp_cur) else $error("pump current not written");

    property p_txen;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && (addr_i == `PPC_OFS_TX_ENABLE_A || addr_i == `PPC_OFS_TX_ENABLE_B)
            |=> host_tx_enable_o == $past(wdata_i[2]);
    endproperty
    a_txen: assert property (p_txen) else $error("enable not written");

    property p_carrier_mid;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_CARRIER_MID |=> carrier_word_o[15:8] == $past(wdata_i)
            && $stable(carrier_word_o[23:16]) && $stable(carrier_word_o[7:0]);
    endproperty
    a_carrier_mid: assert property (p_carrier_mid) else $error("carrier byte wrong");

    property p_alias_read;
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i && addr_i == `PPC_OFS_TX_ENABLE_B |=> rvalid_o
            && rdata_o[2] == $past(host_tx_enable_o) && rdata_o[7:3] == 5'h00;
    endproperty
    a_alias_read: assert property (p_alias_read) else $error("alias read wrong");

    property p_unmapped;
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i && addr_i == 8'h0E |=> rvalid_o && rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

    property p_cap_readback;
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_PA_SHUNT_CAP ##1 rd_i && !wr_i && addr_i == `PPC_OFS_PA_SHUNT_CAP
            |=> rdata_o == {3'h0, $past(wdata_i[4:0], 2)};
    endproperty
    a_cap_readback: assert property (p_cap_readback) else $error("readback wrong");

    c_alias_write: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_TX_ENABLE_B && wdata_i[2] ##1 host_tx_enable_o);
    c_integer_n: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_SYNTH_MODE && !wdata_i[5] ##1 !synth_fraction_select_o);
    c_full_carrier: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PPC_OFS_CARRIER_HIGH ##1 wr_i && addr_i == `PPC_OFS_CARRIER_MID
        ##1 wr_i && addr_i == `PPC_OFS_CARRIER_LOW);

endmodule // ppc_regs
`default_nettype wire

/* sim/ppc_host_model.sv */
// Host side of the register port, standing in for the I2C engine
`timescale 1ns/10ps
`default_nettype none
module ppc_host_model (
    input  wire logic       clk_i,
    output var  logic [7:0] addr_o,
    output var  logic       wr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       rd_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end

    // offset none in integer-N, reserved zero
    function automatic logic [7:0] synth_byte(input logic [1:0] off, input logic frac,
                                              input logic [1:0] div, input logic lo);
        return {(frac ? off : 2'h0), frac, 2'h0, div, lo};
    endfunction

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // Released lines flip so a stale copy cannot pass
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask

    // Write and read together, then read again the next cycle
    task automatic write_read_reg(input logic [7:0] a, input logic [7:0] d,
                                  output logic [7:0] d_old, output logic [7:0] d_new);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        rd_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        #1;
        d_old = rdata_i;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        d_new = rdata_i;
    endtask

    // Ok only if the answer pulse lasts exactly one cycle
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
        ok = (rvalid_i === 1'b1);
        @(posedge clk_i);
        #1;
        ok = ok && (rvalid_i === 1'b0);
    endtask
endmodule // ppc_host_model
`default_nettype wire

/* sim/ppc_regs_tb.sv */
// Self-checking bench for the PA and PLL register slice
`timescale 1ns/10ps
`default_nettype none
`include "ppc_consts.svh"
module ppc_regs_tb;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd, rvalid, frac, lo, txen;
    logic [4:0]  cap;
    logic [12:0] cap_ff;
    logic [1:0]  off, div, cp;
    logic [23:0] carrier, cw;
    logic [7:0]  b, old_b, new_b;
    logic [7:0]  ofs [8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10};
    logic [7:0]  rst_v [8] = '{8'h00, 8'h60, 8'h00, 8'h00, 8'h13, 8'hB0, 8'h00, 8'h00};
    logic [7:0]  cbytes [3] = '{8'h20, 8'h5A, 8'hC3};
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #2.5 clk_i = ~clk_i;

    ppc_regs ppc_regs_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wr_i(wr),
        .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .rvalid_o(rvalid),
        .pa_shunt_cap_code_o(cap), .pa_shunt_cap_ff_o(cap_ff), .cp_offset_level_o(off),
        .synth_fraction_select_o(frac), .vco_post_divider_o(div), .lo_source_select_o(lo),
        .cp_current_code_o(cp), .host_tx_enable_o(txen), .carrier_word_o(carrier));
    ppc_host_model ppc_host_model_inst (.clk_i(clk_i), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

    task automatic conclude();
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        ppc_host_model_inst.read_reg(a, d, ok);
        chk("rvalid pulse", 32'h1, {31'h0, ok});
        chk($sformatf("read of %h", a), {24'h0, e}, {24'h0, d});
    endtask

    task automatic reset_chk();
        chk("fields at reset", 32'h000000C0, {cap, cap_ff, off, frac, div, lo, cp, txen});
        chk("carrier at reset", 32'h0013B000, {8'h0, carrier});
        for (int i = 0; i < 8; i++) begin
            rchk(ofs[i], rst_v[i]);
        end
    endtask

    // ----------------------------------------------------------------
    // Hang guard, far above the roughly six hundred cycles the run needs
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        reset_chk();
        for (int c = 0; c < 32; c++) begin
            ppc_host_model_inst.write_reg(`PPC_OFS_PA_SHUNT_CAP, 8'(c));
            chk("cap code", c, {27'h0, cap});
            chk("cap fF", 32'(c * 13'h0AF), {19'h0, cap_ff});
            rchk(`PPC_OFS_PA_SHUNT_CAP, 8'(c));
        end
        // Same-cycle read sees the old code, the next read the new one
        ppc_host_model_inst.write_read_reg(`PPC_OFS_PA_SHUNT_CAP, 8'h0A, old_b, new_b);
        chk("read beside write", 32'h1F, {24'h0, old_b});
        chk("read after write", 32'h0A, {24'h0, new_b});
        for (int i = 0; i < 64; i++) begin
            b = ppc_host_model_inst.synth_byte(2'(i >> 4), i[3], i[2:1], i[0]);
            ppc_host_model_inst.write_reg(`PPC_OFS_SYNTH_MODE, b);
            chk("synth fields", {26'h0, b[7:5], b[2:0]}, {26'h0, off, frac, div, lo});
            rchk(`PPC_OFS_SYNTH_MODE, b);
        end
        for (int i = 0; i < 4; i++) begin
            ppc_host_model_inst.write_reg(`PPC_OFS_CHARGE_PUMP, 8'(i));
            chk("pump code", i, {30'h0, cp});
            rchk(`PPC_OFS_CHARGE_PUMP, 8'(i));
        end
        ppc_host_model_inst.write_reg(`PPC_OFS_TX_ENABLE_A, 8'h04);
        chk("tx enable", 32'h1, {31'h0, txen});
        rchk(`PPC_OFS_TX_ENABLE_B, 8'h04);
        ppc_host_model_inst.write_reg(`PPC_OFS_TX_ENABLE_B, 8'h00);
        chk("tx enable", 32'h0, {31'h0, txen});
        rchk(`PPC_OFS_TX_ENABLE_A, 8'h00);
        cw = 24'h13B000;
        for (int k = 0; k < 3; k++) begin
            ppc_host_model_inst.write_reg(8'(`PPC_OFS_CARRIER_HIGH + k), cbytes[k]);
            cw[23 - 8 * k -: 8] = cbytes[k];
            chk("carrier word", {8'h0, cw}, {8'h0, carrier});
            rchk(8'(`PPC_OFS_CARRIER_HIGH + k), cbytes[k]);
        end
        // Unmapped places: write dropped, read answers zero
        ppc_host_model_inst.write_reg(8'h0E, 8'hFF);
        chk("carrier after stray write", {8'h0, cw}, {8'h0, carrier});
        rchk(8'h0E, 8'h00);
        rchk(8'hFF, 8'h00);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        reset_chk();
        conclude();
    end
endmodule // ppc_regs_tb
`default_nettype wire
